// [include/memory_address_map_regs.svh]
// Purpose: constants for the program counter and data memory address map
// Assumes: one core clock, synchronous active-high reset
// Notes:   offsets are data-memory addresses within a page
// Function
// - program counter is ten bits wide, covering 1K program words.
// - power-on reset loads the program counter with 0x000.
// - software interrupt jumps to program address 0x001.
// - every hardware interrupt jumps to common vector 0x008.
// - short call and accumulator jump or call reach 256 locations.
// - page jump reaches 512 locations.
// - long call and long jump reach the whole program space.
// - calls and accepted interrupts push next address onto stack top.
// - subroutine, literal and interrupt exits pop stack top into program counter.
// - general page has four banks chosen by pointer bits 7 to 6.
// - indirect access: bank from pointer 7:6, location from pointer 5:0.
// - direct access: bank from pointer 7:6, location from opcode 5:0.
// - ordinary instructions reach general page special registers.
// - special registers live in bank 0 only; other banks mirror them.
// - SRAM sits at 0x10 to 0x3F of bank 0; other banks mirror it.
// - general page decodes timer, pc low, status, pointer, port, enable, flags.
// - control page reached only by control page write and read.
// - special page reached only by special page write and read.
// - control and special page accesses ignore pointer bank bits.
// - control and special pages each decode their own 0x0 to 0xF.
// - indirect port has no storage; it acts on the pointed register.
// - timer0 reads live count; writes replace running count at once.
// - timer0 clock chosen from instruction clock, external pin or slow oscillator.
// - page jump takes bits 8:0 from instruction, bit 9 from buffer bit 1.
`ifndef MEMORY_ADDRESS_MAP_REGS_SVH
`define MEMORY_ADDRESS_MAP_REGS_SVH

`define PC_WIDTH            10
`define RESET_VECTOR        10'h000
`define SOFT_INT_VECTOR     10'h001
`define HARD_INT_VECTOR     10'h008
`define STACK_DEPTH         8

`define ADDR_INDIRECT       6'h00
`define ADDR_TIMER0         6'h01
`define ADDR_PC_LOW         6'h02
`define ADDR_STATUS         6'h03
`define ADDR_POINTER        6'h04
`define ADDR_PORT           6'h06
`define ADDR_POWER          6'h08
`define ADDR_WAKE           6'h09
`define ADDR_PC_HIGH        6'h0a
`define ADDR_PULLDOWN       6'h0b
`define ADDR_PULLUP         6'h0c
`define ADDR_INT_ENABLE     6'h0e
`define ADDR_INT_FLAGS      6'h0f
`define SRAM_BASE           6'h10

`define CTL_PORT_DIR        4'h6
`define CTL_T0_PRESCALE     4'ha
`define SPC_TIMER1          4'h0
`define SPC_OSC_CTRL        4'hf

`define BANK_MSB            7
`define BANK_LSB            6

`define RST_STATUS          8'h18
`define RST_POWER           8'h88
`define RST_WAKE            8'h3f
`define RST_PULLDOWN        8'hff
`define RST_PULLUP          8'h3f
`define RST_PORT_DIR        8'hff
`define RST_ZERO            8'h00

`define T0SRC_INST          2'h0
`define T0SRC_EXT           2'h1
`define T0SRC_SLOW          2'h2

`endif

// [include/memory_address_map_pkg.sv]
// Purpose: types shared by the address map block
// Assumes: nothing
// Notes:   constants live in the regs header
package memory_address_map_pkg;

   typedef enum logic [3:0] {
      FLOW_NEXT,
      FLOW_SHORT_CALL,
      FLOW_ACC_JUMP,
      FLOW_ACC_CALL,
      FLOW_PAGE_JUMP,
      FLOW_LONG_JUMP,
      FLOW_LONG_CALL,
      FLOW_SUB_EXIT,
      FLOW_LIT_EXIT,
      FLOW_INT_EXIT,
      FLOW_SOFT_INT,
      FLOW_HARD_INT,
      FLOW_HOLD
   } flow_op_t;

   typedef enum logic [2:0] {
      DATA_NONE,
      DATA_DIRECT,
      DATA_CONTROL,
      DATA_SPECIAL
   } data_space_t;

   typedef struct packed {
      flow_op_t    op;
      logic [9:0]  target;
      logic [7:0]  acc;
   } flow_req_t;

   typedef struct packed {
      data_space_t space;
      logic        wr;
      logic        rd;
      logic [5:0]  opcode_addr;
      logic [7:0]  wdata;
   } data_req_t;

endpackage : memory_address_map_pkg

// [rtl/memory_address_map.sv]
// Purpose: program counter, return stack and data memory decode of the core
// Assumes: core decode issues at most one flow and one data request per cycle
// Notes:   read data is registered and appears the cycle after the request
`timescale 1ns/10ps
`include "memory_address_map_regs.svh"

module memory_address_map
   import memory_address_map_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        reset_i,
   input  wire flow_req_t   flow_i,
   input  wire data_req_t   data_i,
   input  wire logic        inst_tick_i,
   input  wire logic        ext_clk_i,
   input  wire logic        slow_clk_i,
   input  wire logic [1:0]  timer0_src_i,
   input  wire logic [5:0]  port_pins_i,
   output logic [9:0]       pc_o,
   output logic [7:0]       rdata_o,
   output logic             rvalid_o,
   output logic [7:0]       port_data_o,
   output logic [7:0]       port_dir_o,
   output logic [7:0]       timer0_prescale_o,
   output logic             stack_overflow_o
);

   // ************************************************************
   // storage
   // ************************************************************
   logic [9:0]  stack_ff [`STACK_DEPTH];
   logic [2:0]  sp_ff;
   logic [7:0]  sram_ff  [48];
   logic [7:0]  timer0_ff;
   logic [7:0]  status_ff;
   logic [7:0]  pointer_ff;
   logic [7:0]  power_ff;
   logic [7:0]  wake_ff;
   logic [7:0]  pc_high_ff;
   logic [7:0]  pulldown_ff;
   logic [7:0]  pullup_ff;
   logic [7:0]  int_enable_ff;
   logic [7:0]  int_flags_ff;
   logic [7:0]  spc_ff [16];
   logic [9:0]  nxt_pc;
   logic [9:0]  pc_plus;
   logic        push;
   logic        pop;
   logic [5:0]  gen_addr;
   logic [1:0]  bank;
   logic        gen_wr;
   logic        gen_rd;
   logic [7:0]  gen_rdata;
   logic        ext_d_ff;
   logic        slow_d_ff;
   logic        t0_tick;

   assign pc_plus = pc_o + 10'h001;

   // ************************************************************
   // program counter
   // ************************************************************
   always_comb
   begin
      nxt_pc = pc_plus;
      push   = 1'b0;
      pop    = 1'b0;
      case (flow_i.op)
         FLOW_NEXT       : nxt_pc = pc_plus;
         FLOW_HOLD       : nxt_pc = pc_o;
         FLOW_SHORT_CALL :
         begin
            nxt_pc = {pc_high_ff[1:0], flow_i.target[7:0]};
            push   = 1'b1;
         end
         FLOW_ACC_JUMP   : nxt_pc = {pc_high_ff[1:0], flow_i.acc};
         FLOW_ACC_CALL   :
         begin
            nxt_pc = {pc_high_ff[1:0], flow_i.acc};
            push   = 1'b1;
         end
         FLOW_PAGE_JUMP  : nxt_pc = {pc_high_ff[1], flow_i.target[8:0]};
         FLOW_LONG_JUMP  : nxt_pc = flow_i.target;
         FLOW_LONG_CALL  :
         begin
            nxt_pc = flow_i.target;
            push   = 1'b1;
         end
         FLOW_SUB_EXIT,
         FLOW_LIT_EXIT,
         FLOW_INT_EXIT   :
         begin
            nxt_pc = stack_ff[sp_ff - 3'h1];
            pop    = 1'b1;
         end
         FLOW_SOFT_INT   :
         begin
            nxt_pc = `SOFT_INT_VECTOR;
            push   = 1'b1;
         end
         FLOW_HARD_INT   :
         begin
            nxt_pc = `HARD_INT_VECTOR;
            push   = 1'b1;
         end
         default         : nxt_pc = pc_plus;
      endcase
      // writing the low byte redirects execution through the high buffer
      if (gen_wr && gen_addr == `ADDR_PC_LOW)
         nxt_pc = {pc_high_ff[1:0], data_i.wdata};
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         pc_o <= `RESET_VECTOR;
      else
         pc_o <= nxt_pc;
   end

   // ************************************************************
   // return stack
   // ************************************************************
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         sp_ff            <= 3'h0;
         stack_overflow_o <= 1'b0;
      end
      else if (push)
      begin
         stack_ff[sp_ff] <= pc_plus;
         sp_ff           <= sp_ff + 3'h1;
         if (sp_ff == 3'h7)
            stack_overflow_o <= 1'b1;
      end
      else if (pop)
         sp_ff <= sp_ff - 3'h1;
   end

   // ************************************************************
   // general page decode
   // ************************************************************
   always_comb
   begin
      bank     = pointer_ff[`BANK_MSB:`BANK_LSB];
      gen_addr = data_i.opcode_addr;
      if (data_i.opcode_addr == `ADDR_INDIRECT)
         gen_addr = pointer_ff[5:0];
      gen_wr = (data_i.space == DATA_DIRECT) && data_i.wr;
      gen_rd = (data_i.space == DATA_DIRECT) && data_i.rd;
   end

   // bank is decoded but all four banks mirror bank 0 in this part
   always_comb
   begin
      gen_rdata = `RST_ZERO;
      if (gen_addr >= `SRAM_BASE)
         gen_rdata = sram_ff[gen_addr - `SRAM_BASE];
      else
         case (gen_addr)
            `ADDR_TIMER0     : gen_rdata = timer0_ff;
            `ADDR_PC_LOW     : gen_rdata = pc_o[7:0];
            `ADDR_STATUS     : gen_rdata = status_ff;
            `ADDR_POINTER    : gen_rdata = pointer_ff;
            `ADDR_PORT       : gen_rdata = {port_data_o[7:6], port_pins_i};
            `ADDR_POWER      : gen_rdata = power_ff;
            `ADDR_WAKE       : gen_rdata = wake_ff;
            `ADDR_PC_HIGH    : gen_rdata = pc_high_ff;
            `ADDR_PULLDOWN   : gen_rdata = pulldown_ff;
            `ADDR_PULLUP     : gen_rdata = pullup_ff;
            `ADDR_INT_ENABLE : gen_rdata = int_enable_ff;
            `ADDR_INT_FLAGS  : gen_rdata = int_flags_ff;
            default          : gen_rdata = `RST_ZERO;
         endcase
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (gen_wr && gen_addr >= `SRAM_BASE)
         sram_ff[gen_addr - `SRAM_BASE] <= data_i.wdata;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         status_ff     <= `RST_STATUS;
         pointer_ff    <= `RST_ZERO;
         port_data_o   <= `RST_ZERO;
         power_ff      <= `RST_POWER;
         wake_ff       <= `RST_WAKE;
         pc_high_ff    <= `RST_ZERO;
         pulldown_ff   <= `RST_PULLDOWN;
         pullup_ff     <= `RST_PULLUP;
         int_enable_ff <= `RST_ZERO;
         int_flags_ff  <= `RST_ZERO;
      end
      else if (gen_wr)
         case (gen_addr)
            `ADDR_STATUS     : status_ff     <= data_i.wdata;
            `ADDR_POINTER    : pointer_ff    <= data_i.wdata;
            `ADDR_PORT       : port_data_o   <= data_i.wdata;
            `ADDR_POWER      : power_ff      <= data_i.wdata;
            `ADDR_WAKE       : wake_ff       <= data_i.wdata;
            `ADDR_PC_HIGH    : pc_high_ff    <= data_i.wdata;
            `ADDR_PULLDOWN   : pulldown_ff   <= data_i.wdata;
            `ADDR_PULLUP     : pullup_ff     <= data_i.wdata;
            `ADDR_INT_ENABLE : int_enable_ff <= data_i.wdata;
            `ADDR_INT_FLAGS  : int_flags_ff  <= data_i.wdata;
            default          : ;
         endcase
   end

   // ************************************************************
   // timer0 count
   // ************************************************************
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         ext_d_ff  <= 1'b0;
         slow_d_ff <= 1'b0;
      end
      else
      begin
         ext_d_ff  <= ext_clk_i;
         slow_d_ff <= slow_clk_i;
      end
   end

   always_comb
   begin
      case (timer0_src_i)
         `T0SRC_INST : t0_tick = inst_tick_i;
         `T0SRC_EXT  : t0_tick = ext_clk_i & ~ext_d_ff;
         `T0SRC_SLOW : t0_tick = slow_clk_i & ~slow_d_ff;
         default     : t0_tick = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         timer0_ff <= `RST_ZERO;
      else if (gen_wr && gen_addr == `ADDR_TIMER0)
         timer0_ff <= data_i.wdata;
      else if (t0_tick)
         timer0_ff <= timer0_ff + 8'h01;
   end

   // ************************************************************
   // control and special pages
   // ************************************************************
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         port_dir_o        <= `RST_PORT_DIR;
         timer0_prescale_o <= `RST_ZERO;
         for (int i = 0; i < 16; i++)
            spc_ff[i] <= `RST_ZERO;
      end
      else if (data_i.wr && data_i.space == DATA_CONTROL)
         case (data_i.opcode_addr[3:0])
            `CTL_PORT_DIR    : port_dir_o        <= data_i.wdata;
            `CTL_T0_PRESCALE : timer0_prescale_o <= data_i.wdata;
            default          : ;
         endcase
      else if (data_i.wr && data_i.space == DATA_SPECIAL)
         spc_ff[data_i.opcode_addr[3:0]] <= data_i.wdata;
   end

   // ************************************************************
   // read data
   // ************************************************************
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         rdata_o  <= `RST_ZERO;
         rvalid_o <= 1'b0;
      end
      else
      begin
         rvalid_o <= data_i.rd && (data_i.space != DATA_NONE);
         rdata_o  <= `RST_ZERO;
         if (gen_rd)
            rdata_o <= gen_rdata;
         else if (data_i.rd && data_i.space == DATA_CONTROL)
            case (data_i.opcode_addr[3:0])
               `CTL_PORT_DIR    : rdata_o <= port_dir_o;
               `CTL_T0_PRESCALE : rdata_o <= timer0_prescale_o;
               default          : rdata_o <= `RST_ZERO;
            endcase
         else if (data_i.rd && data_i.space == DATA_SPECIAL)
            rdata_o <= spc_ff[data_i.opcode_addr[3:0]];
      end
   end

endmodule : memory_address_map

// [bench/memory_address_map_chk.sv]
// Purpose: port assertions for the address map block
// Assumes: sees top-level ports only, one clock domain
// Notes:   bound to the design at the foot of this file
`timescale 1ns/10ps
module memory_address_map_chk
   import memory_address_map_pkg::*;
(
   input wire logic        sys_clk_i,
   input wire logic        reset_i,
   input wire flow_req_t   flow_i,
   input wire data_req_t   data_i,
   input wire logic [9:0]  pc_o,
   input wire logic [7:0]  rdata_o,
   input wire logic        rvalid_o,
   input wire logic [7:0]  port_dir_o,
   input wire logic        stack_overflow_o
);
   // ***********************************************
   // flow and read checks
   // ***********************************************
   logic no_wr;
   assign no_wr = !data_i.wr;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   AST_RESET_VECTOR: assert property (disable iff (1'b0) reset_i |=> pc_o == 10'h000
      && port_dir_o == 8'hff && !rvalid_o) else $error("reset state wrong");
   AST_SOFT_VECTOR: assert property (flow_i.op == FLOW_SOFT_INT && no_wr |=> pc_o == 10'h001)
      else $error("soft interrupt vector wrong");
   AST_HARD_VECTOR: assert property (flow_i.op == FLOW_HARD_INT && no_wr |=> pc_o == 10'h008)
      else $error("hard interrupt vector wrong");
   AST_LONG_TARGET: assert property (flow_i.op == FLOW_LONG_JUMP && no_wr
      |=> pc_o == $past(flow_i.target)) else $error("long jump target wrong");
   AST_PC_STEP: assert property (flow_i.op == FLOW_NEXT && no_wr
      |=> pc_o == $past(pc_o) + 10'h001) else $error("pc increment wrong");
   AST_CALL_RETURN: assert property ((flow_i.op == FLOW_LONG_CALL && no_wr ##1
      flow_i.op inside {FLOW_SUB_EXIT, FLOW_LIT_EXIT, FLOW_INT_EXIT} && no_wr)
      |=> pc_o == $past(pc_o, 2) + 10'h001) else $error("return address wrong");
   AST_PAGE_LOW: assert property (flow_i.op == FLOW_PAGE_JUMP && no_wr
      |=> pc_o[8:0] == $past(flow_i.target[8:0])) else $error("page jump bits wrong");
   AST_ACC_LOW: assert property (flow_i.op inside {FLOW_ACC_JUMP, FLOW_ACC_CALL} && no_wr
      |=> pc_o[7:0] == $past(flow_i.acc)) else $error("accumulator target wrong");
   AST_READ_PULSE: assert property (rvalid_o == $past(data_i.rd
      && data_i.space != DATA_NONE)) else $error("read valid timing wrong");
   AST_IDLE_ZERO: assert property (!rvalid_o |-> rdata_o == 8'h00)
      else $error("read data not zero when idle");
   AST_OVF_STICKY: assert property (stack_overflow_o |=> stack_overflow_o)
      else $error("overflow flag dropped");
endmodule : memory_address_map_chk

bind memory_address_map memory_address_map_chk u_memory_address_map_chk (
   .sys_clk_i(sys_clk_i), .reset_i(reset_i), .flow_i(flow_i), .data_i(data_i),
   .pc_o(pc_o), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .port_dir_o(port_dir_o),
   .stack_overflow_o(stack_overflow_o));

// [bench/core_decode_model.sv]
// Purpose: stand-in for the core decode unit issuing flow and data requests
// Assumes: one request of each kind per cycle
// Notes:   requests change 1 ns after the rising edge and hold until the next call
`timescale 1ns/10ps
module core_decode_model
   import memory_address_map_pkg::*;
(
   input  wire logic  sys_clk_i,
   output flow_req_t  flow_o,
   output data_req_t  data_o
);
   // ***********************************************
   // request driver
   // ***********************************************
   initial
   begin
      flow_o = '{FLOW_HOLD, 10'h000, 8'h00};
      data_o = '{DATA_NONE, 1'b0, 1'b0, 6'h00, 8'h00};
   end
   task automatic step(input flow_op_t op, input logic [9:0] t, input logic [7:0] ac,
                       input data_space_t sp, input logic w, input logic r,
                       input logic [5:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      #1;
      flow_o = '{op, t, ac};
      data_o = '{sp, w, r, a, d};
   endtask : step
endmodule : core_decode_model

// [bench/test_memory_address_map.sv]
// Purpose: self-checking bench for the address map block
// Assumes: reference model of pc, stack and pc high buffer kept here
// Notes:   random values from an lfsr with a fixed start
`timescale 1ns/10ps
module test_memory_address_map;
   import memory_address_map_pkg::*;
   // ***********************************************
   // signals, model and helpers
   // ***********************************************
   logic sys_clk_i, reset_i, inst_tick_i, ext_clk_i, slow_clk_i, rvalid_o, stack_overflow_o;
   logic [1:0] timer0_src_i, ph;
   logic [5:0] port_pins_i, a;
   logic [7:0] rdata_o, port_data_o, port_dir_o, timer0_prescale_o;
   logic [9:0] pc_o, pc_m, stk[$];
   logic [31:0] r = 32'h039aad9b;
   flow_req_t flow_i;
   data_req_t data_i;
   flow_op_t op;
   int err_count = 0;
   int cmp_count = 0;
   flow_op_t ops[12] = '{FLOW_NEXT, FLOW_SHORT_CALL, FLOW_ACC_JUMP, FLOW_ACC_CALL,
      FLOW_PAGE_JUMP, FLOW_LONG_JUMP, FLOW_LONG_CALL, FLOW_SUB_EXIT, FLOW_LIT_EXIT,
      FLOW_INT_EXIT, FLOW_SOFT_INT, FLOW_HARD_INT};
   memory_address_map u_memory_address_map (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .flow_i(flow_i), .data_i(data_i), .inst_tick_i(inst_tick_i), .ext_clk_i(ext_clk_i),
      .slow_clk_i(slow_clk_i), .timer0_src_i(timer0_src_i), .port_pins_i(port_pins_i),
      .pc_o(pc_o), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .port_data_o(port_data_o),
      .port_dir_o(port_dir_o), .timer0_prescale_o(timer0_prescale_o),
      .stack_overflow_o(stack_overflow_o));
   core_decode_model u_core_decode_model (.sys_clk_i(sys_clk_i), .flow_o(flow_i),
      .data_o(data_i));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
      cmp_count++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic idle(input int n);
      repeat (n) u_core_decode_model.step(FLOW_HOLD, 10'h000, 8'h00, DATA_NONE, 0, 0, 0, 0);
   endtask : idle
   task automatic wr(input data_space_t sp, input logic [5:0] ad, input logic [7:0] d);
      u_core_decode_model.step(FLOW_HOLD, 10'h000, 8'h00, sp, 1'b1, 1'b0, ad, d);
      idle(1);
      if (sp == DATA_DIRECT && ad == 6'h0a)
         ph = d[1:0];
      if (sp == DATA_DIRECT && ad == 6'h02)
         pc_m = {ph, d};
   endtask : wr
   task automatic rchk(input string n, input data_space_t sp, input logic [5:0] ad,
                       input logic [7:0] e);
      u_core_decode_model.step(FLOW_HOLD, 10'h000, 8'h00, sp, 1'b0, 1'b1, ad, 8'h00);
      idle(1);
      chk("rvalid", 10'h001, {9'h000, rvalid_o});
      chk(n, {2'b00, e}, {2'b00, rdata_o});
   endtask : rchk
   task automatic go(input flow_op_t o, input logic [9:0] t, input logic [7:0] ac);
      logic [9:0] nx;
      nx = pc_m + 10'h001;
      u_core_decode_model.step(o, t, ac, DATA_NONE, 1'b0, 1'b0, 6'h00, 8'h00);
      idle(1);
      if (o inside {FLOW_SHORT_CALL, FLOW_ACC_CALL, FLOW_LONG_CALL, FLOW_SOFT_INT, FLOW_HARD_INT})
         stk.push_back(nx);
      case (o)
         FLOW_NEXT: pc_m = nx;
         FLOW_SHORT_CALL: pc_m = {ph, t[7:0]};
         FLOW_ACC_JUMP, FLOW_ACC_CALL: pc_m = {ph, ac};
         FLOW_PAGE_JUMP: pc_m = {ph[1], t[8:0]};
         FLOW_LONG_JUMP, FLOW_LONG_CALL: pc_m = t;
         FLOW_SOFT_INT: pc_m = 10'h001;
         FLOW_HARD_INT: pc_m = 10'h008;
         FLOW_SUB_EXIT, FLOW_LIT_EXIT, FLOW_INT_EXIT: pc_m = stk.pop_back();
         default: ;
      endcase
      chk("pc", pc_m, pc_o);
   endtask : go
   task automatic pulse();
      inst_tick_i = 1'b1;
      ext_clk_i = 1'b1;
      slow_clk_i = 1'b1;
      idle(1);
      inst_tick_i = 1'b0;
      idle(1);
      ext_clk_i = 1'b0;
      slow_clk_i = 1'b0;
      idle(2);
   endtask : pulse
   // ***********************************************
   // clock, watchdog and scenarios
   // ***********************************************
   initial
   begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end
   initial
   begin
      #200000;
      err_count++;
      final_report();
   end
   initial
   begin
      {reset_i, inst_tick_i, ext_clk_i, slow_clk_i} = 4'h8;
      {timer0_src_i, port_pins_i, ph, pc_m} = '0;
      repeat (6) @(posedge sys_clk_i);
      #1 reset_i = 1'b0;
      chk("pc reset", 10'h000, pc_o);
      chk("dir reset", 10'h0ff, {2'b00, port_dir_o});
      foreach (ops[k]) wr(DATA_DIRECT, (k % 3 == 0) ? 6'h05 : (k % 3 == 1) ? 6'h07 : 6'h0d, 8'hff);
      rchk("status", DATA_DIRECT, 6'h03, 8'h18);
      rchk("power", DATA_DIRECT, 6'h08, 8'h88);
      rchk("pullup", DATA_DIRECT, 6'h0c, 8'h3f);
      for (int k = 0; k < 3; k++) rchk("unused", DATA_DIRECT, (k == 0) ? 6'h05 : (k == 1) ? 6'h07 : 6'h0d, 8'h00);
      foreach (ops[k]) go(ops[k], 10'h2c7, 8'h9a);
      for (int i = 0; i < 40; i++)
      begin
         r = lfsr(r);
         wr(DATA_DIRECT, 6'h0a, {6'h00, r[1:0]});
         op = ops[r[5:2] % 12];
         if (op inside {FLOW_SUB_EXIT, FLOW_LIT_EXIT, FLOW_INT_EXIT} && stk.size() == 0)
            op = FLOW_NEXT;
         if (stk.size() >= 7)
            op = FLOW_LIT_EXIT;
         go(op, r[17:8], r[25:18]);
      end
      while (stk.size() > 0) go(FLOW_INT_EXIT, 10'h000, 8'h00);
      u_core_decode_model.step(FLOW_LONG_CALL, 10'h3a1, 0, DATA_NONE, 0, 0, 0, 0);
      u_core_decode_model.step(FLOW_SUB_EXIT, 10'h000, 0, DATA_NONE, 0, 0, 0, 0);
      idle(1);
      chk("back to back return", pc_m + 10'h001, pc_o);
      wr(DATA_DIRECT, 6'h02, 8'h77);
      chk("pc low write", pc_m, pc_o);
      for (int i = 0; i < 8; i++)
      begin
         r = lfsr(r);
         a = (r[5:0] < 6'h10) ? (r[5:0] | 6'h10) : r[5:0];
         wr(DATA_DIRECT, 6'h04, {r[7:6], 6'h00});
         wr(DATA_DIRECT, a, r[15:8]);
         wr(DATA_DIRECT, 6'h04, {~r[7:6], a});
         rchk("sram mirror", DATA_DIRECT, a, r[15:8]);
         rchk("indirect read", DATA_DIRECT, 6'h00, r[15:8]);
         rchk("pointer", DATA_DIRECT, 6'h04, {~r[7:6], a});
         wr(DATA_DIRECT, 6'h00, r[23:16]);
         rchk("indirect write", DATA_DIRECT, a, r[23:16]);
         port_pins_i = r[29:24];
         wr(DATA_DIRECT, 6'h06, r[31:24]);
         chk("port latch", {2'b00, r[31:24]}, {2'b00, port_data_o});
         rchk("port read", DATA_DIRECT, 6'h06, {r[31:30], r[29:24]});
      end
      wr(DATA_CONTROL, 6'h06, 8'h5a);
      chk("dir write", 10'h05a, {2'b00, port_dir_o});
      chk("port kept", {2'b00, r[31:24]}, {2'b00, port_data_o});
      wr(DATA_CONTROL, 6'h0a, 8'h3c);
      chk("prescale", 10'h03c, {2'b00, timer0_prescale_o});
      wr(DATA_SPECIAL, 6'h06, 8'h77);
      chk("dir kept", 10'h05a, {2'b00, port_dir_o});
      rchk("special", DATA_SPECIAL, 6'h06, 8'h77);
      rchk("control", DATA_CONTROL, 6'h06, 8'h5a);
      for (int s = 0; s < 4; s++)
      begin
         timer0_src_i = 2'(s);
         wr(DATA_DIRECT, 6'h01, 8'hfe);
         pulse();
         pulse();
         rchk("timer0", DATA_DIRECT, 6'h01, (s < 3) ? 8'h00 : 8'hfe);
      end
      repeat (9) go(FLOW_LONG_CALL, 10'h155, 8'h00);
      chk("overflow", 10'h001, {9'h000, stack_overflow_o});
      reset_i = 1'b1;
      idle(6);
      reset_i = 1'b0;
      chk("overflow clear", 10'h000, {9'h000, stack_overflow_o});
      chk("pc reset", 10'h000, pc_o);
      final_report();
   end
endmodule : test_memory_address_map
